// *** asc_regs.svh ***
// register indices, field positions, reset values and counts of the adc sequencer
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// register indices; byte address on the bus is four times the index
`define ASC_IDX_SCR    8'h57
`define ASC_IDX_ICLK   8'h58
`define ASC_IDX_RH0    8'h59
`define ASC_IDX_RL0    8'h5a
`define ASC_IDX_RL1    8'h5b
`define ASC_IDX_RL2    8'h5c
`define ASC_IDX_RL3    8'h5d
`define ASC_IDX_ASCR   8'h5e

// status/control fields
`define ASC_SCR_DONE   7
`define ASC_SCR_IRQEN  6
`define ASC_SCR_CONT   5
`define ASC_SCR_CH_HI  4
`define ASC_SCR_CH_LO  0

// clock control fields
`define ASC_ICLK_DIV_HI  7
`define ASC_ICLK_DIV_LO  5
`define ASC_ICLK_SRC     4
`define ASC_ICLK_MODE_HI 3
`define ASC_ICLK_MODE_LO 2

// auto-scan control fields
`define ASC_ASCR_AUTO_HI 2
`define ASC_ASCR_AUTO_LO 1
`define ASC_ASCR_SCAN    0

// reset values
`define ASC_SCR_RST    8'h1f
`define ASC_ICLK_RST   8'h04
`define ASC_ASCR_RST   8'h00

// channel codes
`define ASC_CH_OFF     5'h1f
`define ASC_CH_REFH    5'h1d
`define ASC_CH_REFL    5'h1e

// conversion timing in prescaled adc clock ticks
`define ASC_SAR_TICKS     5'd16
`define ASC_SAMPLE_TICKS  5'd6

`endif

// *** asc_pkg.sv ***
// types shared by the adc sequencer modules
package asc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_HALT = 3'b100
    } asc_state_e;

    typedef enum logic [1:0] {
        JM_TRUNC = 2'b00,
        JM_RIGHT = 2'b01,
        JM_LEFT  = 2'b10,
        JM_SIGN  = 2'b11
    } asc_just_e;

    // controls toward the analog front end
    typedef struct packed {
        logic       power;
        logic       sample;
        logic [4:0] chan;
        logic [9:0] dac;
    } asc_afe_s;

endpackage

// *** asc_prescaler.sv ***
// adc clock prescaler: one-cycle tick at the divided adc rate
`timescale 1ns/100ps
`default_nettype none
module asc_prescaler (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       src_bus_i,
    input  wire logic       xclk_en_i,
    input  wire logic [2:0] div_i,
    output logic            tick_o
);
    logic       src_en;
    logic [3:0] mask;
    logic [3:0] cnt_q;

    always_comb begin
        src_en = src_bus_i | xclk_en_i;
        unique case (div_i)
            3'h0:    mask = 4'h0;
            3'h1:    mask = 4'h1;
            3'h2:    mask = 4'h3;
            3'h3:    mask = 4'h7;
            default: mask = 4'hf;
        endcase
        tick_o = src_en && ((cnt_q & mask) == mask);
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 4'h0;
        end else if (src_en) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** asc_sar_engine.sv ***
// successive approximation sequencer for one conversion
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"
module asc_sar_engine (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       tick_i,
    input  wire logic       start_i,
    input  wire logic       abort_i,
    input  wire logic       cmp_above_i,
    output logic            busy_o,
    output logic            sample_o,
    output logic            done_o,
    output logic [9:0]      dac_o,
    output logic [9:0]      result_o
);
    logic       armed_q;
    logic [4:0] tcnt_q;
    logic [9:0] sar_q;
    logic [9:0] sar_d;
    logic [3:0] bit_n;
    logic       trial;

    always_comb begin
        trial = (tcnt_q >= `ASC_SAMPLE_TICKS) &&
                (tcnt_q < `ASC_SAMPLE_TICKS + 5'd10);
        bit_n = 4'(5'd9 - (tcnt_q - `ASC_SAMPLE_TICKS));
        sar_d = sar_q;
        if (trial) begin
            sar_d[bit_n] = cmp_above_i;
            if (bit_n != 4'h0) begin
                sar_d[bit_n - 4'h1] = 1'b1;
            end
        end
    end

    assign sample_o = busy_o && (tcnt_q < `ASC_SAMPLE_TICKS);
    // trial code leads sar_q so the registered pin copy already holds
    // it when the comparator is taken at the very next tick
    assign dac_o    = (start_i || abort_i) ? sar_q   :
                      (armed_q && tick_i)  ? 10'h200 :
                      (busy_o && tick_i)   ? sar_d   : sar_q;

    // waiting for the first tick gives the fractional 17th cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            armed_q  <= 1'b0;
            busy_o   <= 1'b0;
            done_o   <= 1'b0;
            tcnt_q   <= 5'h00;
            sar_q    <= 10'h000;
            result_o <= 10'h000;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                armed_q <= 1'b1;
                busy_o  <= 1'b0;
            end else if (abort_i) begin
                armed_q <= 1'b0;
                busy_o  <= 1'b0;
            end else if (armed_q && tick_i) begin
                armed_q <= 1'b0;
                busy_o  <= 1'b1;
                tcnt_q  <= 5'h01;
                sar_q   <= 10'h200;
            end else if (busy_o && tick_i) begin
                sar_q  <= sar_d;
                tcnt_q <= tcnt_q + 5'h01;
                if (tcnt_q == `ASC_SAR_TICKS - 5'd1) begin
                    busy_o   <= 1'b0;
                    done_o   <= 1'b1;
                    result_o <= sar_d;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** asc_top.sv ***
// adc sequencer control: apb registers, conversion sequencing, flags
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "asc_regs.svh"
module asc_top (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        xclk_en_i,
    input  wire logic        stop_i,
    input  wire logic        cmp_above_i,
    output asc_pkg::asc_afe_s afe_o,
    output logic             irq_o
);
    // register state
    logic                 irq_enable_q;
    logic                 continuous_conv_q;
    logic [4:0]           channel_select_q;
    logic                 conv_done_flag_q;
    logic [2:0]           div_q;
    logic                 src_bus_q;
    asc_pkg::asc_just_e   mode_q;
    logic [1:0]           auto_last_q;
    logic                 autoscan_enable_q;
    logic [9:0]           res0_q;
    logic [7:0]           resl_q [1:3];
    logic                 lock_q;
    logic [1:0]           scan_cnt_q;
    asc_pkg::asc_state_e  state_q;

    // bus decode
    logic        access;
    logic        xfer_done;
    logic [7:0]  idx;
    logic        mapped;
    logic        wr_scr;
    logic        wr_iclk;
    logic        wr_ascr;
    logic        rd_h0;
    logic        rd_l0;
    logic        rd_ln;
    logic [31:0] rdata;

    // sequencing
    logic        adc_tick;
    logic        eng_busy;
    logic        eng_sample;
    logic        eng_done;
    logic [9:0]  eng_dac;
    logic [9:0]  eng_result;
    logic        eng_start;
    logic        eng_abort;
    logic        go_wr;
    logic        scan_last;
    logic        repeat_conv;
    logic        powered;
    logic [4:0]  active_ch;

    function automatic logic [7:0] fmt_hi(input asc_pkg::asc_just_e m,
                                          input logic [9:0] r);
        unique case (m)
            asc_pkg::JM_TRUNC: fmt_hi = 8'h00;
            asc_pkg::JM_RIGHT: fmt_hi = {6'h00, r[9:8]};
            asc_pkg::JM_LEFT:  fmt_hi = r[9:2];
            asc_pkg::JM_SIGN:  fmt_hi = {~r[9], r[8:2]};
        endcase
    endfunction

    function automatic logic [7:0] fmt_lo(input asc_pkg::asc_just_e m,
                                          input logic [9:0] r);
        unique case (m)
            asc_pkg::JM_TRUNC: fmt_lo = r[9:2];
            asc_pkg::JM_RIGHT: fmt_lo = r[7:0];
            asc_pkg::JM_LEFT:  fmt_lo = {r[1:0], 6'h00};
            asc_pkg::JM_SIGN:  fmt_lo = {r[1:0], 6'h00};
        endcase
    endfunction

    // side effects fire only on the completing edge of the transfer
    always_comb begin
        access    = psel_i && penable_i;
        xfer_done = access && pready_o;
        idx       = paddr_i[9:2];
        mapped    = (paddr_i[11:10] == 2'h0) &&
                    (idx >= `ASC_IDX_SCR) && (idx <= `ASC_IDX_ASCR);
        wr_scr  = xfer_done && pwrite_i && pstrb_i[0] &&
                  (idx == `ASC_IDX_SCR) && mapped;
        wr_iclk = xfer_done && pwrite_i && pstrb_i[0] &&
                  (idx == `ASC_IDX_ICLK) && mapped;
        wr_ascr = xfer_done && pwrite_i && pstrb_i[0] &&
                  (idx == `ASC_IDX_ASCR) && mapped;
        rd_h0   = xfer_done && !pwrite_i && mapped &&
                  (idx == `ASC_IDX_RH0);
        rd_l0   = xfer_done && !pwrite_i && mapped &&
                  (idx == `ASC_IDX_RL0);
        rd_ln   = xfer_done && !pwrite_i && mapped &&
                  (idx >= `ASC_IDX_RL1) && (idx <= `ASC_IDX_RL3);
    end

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (idx)
            `ASC_IDX_SCR:  rdata[7:0] = {conv_done_flag_q && !irq_enable_q,
                                         irq_enable_q, continuous_conv_q,
                                         channel_select_q};
            `ASC_IDX_ICLK: rdata[7:0] = {div_q, src_bus_q, mode_q, 2'h0};
            `ASC_IDX_RH0:  rdata[7:0] = fmt_hi(mode_q, res0_q);
            `ASC_IDX_RL0:  rdata[7:0] = fmt_lo(mode_q, res0_q);
            `ASC_IDX_RL1:  rdata[7:0] = resl_q[1];
            `ASC_IDX_RL2:  rdata[7:0] = resl_q[2];
            `ASC_IDX_RL3:  rdata[7:0] = resl_q[3];
            `ASC_IDX_ASCR: rdata[7:0] = {5'h00, auto_last_q,
                                         autoscan_enable_q};
            default:       rdata = 32'h0000_0000;
        endcase
    end

    // two-cycle access phase; unmapped addresses answer with an error
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (access && !pready_o) begin
            pready_o  <= 1'b1;
            pslverr_o <= !mapped;
            prdata_o  <= (mapped && !pwrite_i) ? rdata : 32'h0000_0000;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_enable_q      <= 1'(`ASC_SCR_RST >> `ASC_SCR_IRQEN);
            continuous_conv_q <= 1'(`ASC_SCR_RST >> `ASC_SCR_CONT);
            channel_select_q  <= 5'(`ASC_SCR_RST);
            div_q             <= 3'(`ASC_ICLK_RST >> `ASC_ICLK_DIV_LO);
            src_bus_q         <= 1'(`ASC_ICLK_RST >> `ASC_ICLK_SRC);
            mode_q            <= asc_pkg::asc_just_e'(
                2'(`ASC_ICLK_RST >> `ASC_ICLK_MODE_LO));
            auto_last_q       <= 2'(`ASC_ASCR_RST >> `ASC_ASCR_AUTO_LO);
            autoscan_enable_q <= 1'(`ASC_ASCR_RST);
        end else begin
            if (wr_scr) begin
                irq_enable_q      <= pwdata_i[`ASC_SCR_IRQEN];
                continuous_conv_q <= pwdata_i[`ASC_SCR_CONT];
                channel_select_q  <= pwdata_i[`ASC_SCR_CH_HI:`ASC_SCR_CH_LO];
            end
            if (wr_iclk) begin
                div_q     <= pwdata_i[`ASC_ICLK_DIV_HI:`ASC_ICLK_DIV_LO];
                src_bus_q <= pwdata_i[`ASC_ICLK_SRC];
                mode_q    <= asc_pkg::asc_just_e'(
                             pwdata_i[`ASC_ICLK_MODE_HI:`ASC_ICLK_MODE_LO]);
            end
            if (wr_ascr) begin
                auto_last_q <= pwdata_i[`ASC_ASCR_AUTO_HI:`ASC_ASCR_AUTO_LO];
                autoscan_enable_q <= pwdata_i[`ASC_ASCR_SCAN];
            end
        end
    end

    asc_prescaler u_prescaler (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .src_bus_i (src_bus_q),
        .xclk_en_i (xclk_en_i),
        .div_i     (div_q),
        .tick_o    (adc_tick)
    );

    asc_sar_engine u_engine (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .tick_i      (adc_tick),
        .start_i     (eng_start),
        .abort_i     (eng_abort),
        .cmp_above_i (cmp_above_i),
        .busy_o      (eng_busy),
        .sample_o    (eng_sample),
        .done_o      (eng_done),
        .dac_o       (eng_dac),
        .result_o    (eng_result)
    );

    // auto-scan takes precedence, so a stray continuous bit is harmless
    always_comb begin
        powered   = autoscan_enable_q ||
                    (channel_select_q != `ASC_CH_OFF);
        active_ch = autoscan_enable_q ? {3'h0, scan_cnt_q}
                                      : channel_select_q;
        go_wr     = wr_scr && (autoscan_enable_q ||
                    (pwdata_i[`ASC_SCR_CH_HI:`ASC_SCR_CH_LO] !=
                     `ASC_CH_OFF));
        scan_last = scan_cnt_q == auto_last_q;
        repeat_conv = autoscan_enable_q ? !scan_last
                                        : continuous_conv_q;
        eng_start = !stop_i && (go_wr || (!wr_scr &&
                    (state_q == asc_pkg::ST_HALT ||
                     (state_q == asc_pkg::ST_CONV && eng_done &&
                      repeat_conv))));
        eng_abort = stop_i || wr_scr;
    end

    // sequencing state
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_q    <= asc_pkg::ST_IDLE;
            scan_cnt_q <= 2'h0;
        end else begin
            if (wr_scr) begin
                scan_cnt_q <= 2'h0;
                if (!go_wr) begin
                    state_q <= asc_pkg::ST_IDLE;
                end else if (stop_i) begin
                    state_q <= asc_pkg::ST_HALT;
                end else begin
                    state_q <= asc_pkg::ST_CONV;
                end
            end else begin
                unique case (state_q)
                    asc_pkg::ST_IDLE: begin
                        state_q <= asc_pkg::ST_IDLE;
                    end
                    asc_pkg::ST_CONV: begin
                        if (stop_i) begin
                            state_q <= asc_pkg::ST_HALT;
                        end else if (eng_done) begin
                            if (autoscan_enable_q && !scan_last) begin
                                scan_cnt_q <= scan_cnt_q + 2'h1;
                            end
                            if (!repeat_conv) begin
                                state_q <= asc_pkg::ST_IDLE;
                            end
                        end
                    end
                    asc_pkg::ST_HALT: begin
                        if (!stop_i) begin
                            state_q <= asc_pkg::ST_CONV;
                        end
                    end
                    default: state_q <= asc_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // result storage; a frozen pair drops new results for slot zero
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            res0_q    <= 10'h000;
            resl_q[1] <= 8'h00;
            resl_q[2] <= 8'h00;
            resl_q[3] <= 8'h00;
        end else if (eng_done) begin
            if (autoscan_enable_q && scan_cnt_q != 2'h0) begin
                resl_q[scan_cnt_q] <= eng_result[9:2];
            end else if (!lock_q) begin
                res0_q <= eng_result;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            lock_q <= 1'b0;
        end else if (rd_h0 && mode_q != asc_pkg::JM_TRUNC) begin
            lock_q <= 1'b1;
        end else if (rd_l0 || wr_scr || wr_iclk) begin
            lock_q <= 1'b0;
        end
    end

    // completion flag: a finishing conversion beats a same-cycle clear
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            conv_done_flag_q <= 1'b0;
        end else if (eng_done) begin
            conv_done_flag_q <= 1'b1;
        end else if (wr_scr || wr_iclk || rd_l0 || rd_ln) begin
            conv_done_flag_q <= 1'b0;
        end
    end

    // level request, no clock gating so it also wakes from wait
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else if (!irq_enable_q) begin
            irq_o <= 1'b0;
        end else if (eng_done && (!autoscan_enable_q || scan_last)) begin
            irq_o <= 1'b1;
        end else if (rd_l0 || wr_scr) begin
            irq_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            afe_o <= '0;
        end else begin
            afe_o.power  <= powered && !stop_i;
            afe_o.sample <= eng_sample && eng_busy;
            afe_o.chan   <= active_ch;
            afe_o.dac    <= eng_dac;
        end
    end
endmodule
`default_nettype wire

// *** asc_top_props.sv ***
// port-level checks of the adc sequencer control block
`timescale 1ns/100ps
`default_nettype none
module asc_top_props (
    input wire logic              mclk_i,
    input wire logic              sys_rst_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [11:0]       paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [3:0]        pstrb_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic              xclk_en_i,
    input wire logic              stop_i,
    input wire logic              cmp_above_i,
    input wire asc_pkg::asc_afe_s afe_o,
    input wire logic              irq_o
);
    logic       acc;
    logic       scr_wr;
    logic       rl0_rd;
    logic       en_q;
    logic       scan_q;
    logic [4:0] ch_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    assign acc = psel_i && penable_i && pready_o;
    assign scr_wr = acc && pwrite_i && pstrb_i[0] && paddr_i[11:2] == 10'h057;
    assign rl0_rd = acc && !pwrite_i && paddr_i[11:2] == 10'h05a;

    // shadow of what software last wrote, to qualify the checks
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            en_q <= 1'b0;
            ch_q <= 5'h1f;
            scan_q <= 1'b0;
        end else begin
            if (scr_wr) begin
                en_q <= pwdata_i[6];
                ch_q <= pwdata_i[4:0];
            end
            if (acc && pwrite_i && pstrb_i[0] && paddr_i[11:2] == 10'h05e) begin
                scan_q <= pwdata_i[0];
            end
        end
    end

    sequence s_access_start;
        psel_i && !penable_i ##1 psel_i && penable_i;
    endsequence
    sequence s_off_write;
        scr_wr && pwdata_i[4:0] == 5'h1f && !scan_q;
    endsequence

    a_one_wait: assert property (s_access_start |-> !pready_o ##1 pready_o)
        else $error("pready not in second access cycle");
    a_slave_err: assert property (acc |-> pslverr_o ==
        !(paddr_i[11:2] >= 10'h057 && paddr_i[11:2] <= 10'h05e))
        else $error("error response does not match the map");
    a_done_hidden: assert property (acc && !pwrite_i && en_q &&
        paddr_i[11:2] == 10'h057 |-> !prdata_o[7])
        else $error("done flag visible with interrupts on");
    a_irq_needs_en: assert property ($rose(irq_o) |-> en_q)
        else $error("interrupt raised while disabled");
    a_irq_held: assert property (irq_o && en_q && !scr_wr && !rl0_rd
        |=> irq_o) else $error("interrupt dropped without cause");
    a_irq_cleared: assert property (scr_wr || rl0_rd |=> !irq_o)
        else $error("interrupt not withdrawn");
    a_power_off: assert property (s_off_write |-> ##[1:3] !afe_o.power)
        else $error("converter still powered");
    a_mux_route: assert property (afe_o.sample && !scan_q &&
        !$past(scr_wr) |-> afe_o.chan == ch_q)
        else $error("mux code differs from channel field");
    a_scan_chan: assert property (afe_o.sample && scan_q
        |-> afe_o.chan[4:2] == 3'b000) else $error("scan channel out of range");
    a_stop_quiet: assert property (stop_i [*3] |-> !afe_o.sample)
        else $error("sampling during stop");
endmodule

bind asc_top asc_top_props u_props (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .xclk_en_i(xclk_en_i),
    .stop_i(stop_i), .cmp_above_i(cmp_above_i), .afe_o(afe_o), .irq_o(irq_o)
);
`default_nettype wire

// *** asc_afe_model.sv ***
// analog channels and comparator seen by the converter
`timescale 1ns/100ps
`default_nettype none
module asc_afe_model (
    input wire logic              mclk_i,
    input wire asc_pkg::asc_afe_s afe_i,
    output logic                  cmp_o
);
    logic [9:0] lvl;
    logic       rsv;
    logic       tog_q = 1'b0;

    always @(posedge mclk_i) tog_q <= ~tog_q;

    always_comb begin
        rsv = afe_i.chan > 5'h07 && afe_i.chan < 5'h1d;
        if (afe_i.chan <= 5'h07) begin
            lvl = {afe_i.chan[2:0], 7'h55};
        end else if (afe_i.chan == 5'h1d) begin
            lvl = 10'h3ff;
        end else begin
            lvl = 10'h000;
        end
    end
    // unpowered or unused input gives a comparator that wanders
    assign cmp_o = (!afe_i.power || rsv) ? tog_q : lvl >= afe_i.dac;
endmodule
`default_nettype wire

// *** asc_top_tb.sv ***
// self-checking bench of the adc sequencer control block
`timescale 1ns/100ps
`default_nettype none
module asc_top_tb;
    logic              mclk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              psel_i = 1'b0;
    logic              penable_i = 1'b0;
    logic              pwrite_i = 1'b0;
    logic [11:0]       paddr_i = 12'h000;
    logic [31:0]       pwdata_i = 32'h0;
    logic [3:0]        pstrb_i = 4'h1;
    logic [31:0]       prdata_o;
    logic              pready_o;
    logic              pslverr_o;
    logic              xclk_en_i = 1'b0;
    logic              stop_i = 1'b0;
    logic              cmp_above_i;
    asc_pkg::asc_afe_s afe_o;
    logic              irq_o;
    int                err_total = 0;
    int                comparisons = 0;
    int                cyc = 0;
    logic [7:0]        rv;
    logic              ev;
    // clock reg, status reg, expected high and low result bytes
    logic [31:0]       rows [10] = '{32'h1400_0055, 32'h1401_00d5,
        32'h3402_0155, 32'h1803_7540, 32'h5404_0255, 32'h1c05_3540,
        32'h1006_00d5, 32'h1407_03d5, 32'h141d_03ff, 32'h141e_0000};

    asc_top u_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .xclk_en_i(xclk_en_i),
        .stop_i(stop_i), .cmp_above_i(cmp_above_i), .afe_o(afe_o),
        .irq_o(irq_o)
    );
    asc_afe_model u_afe (.mclk_i(mclk_i), .afe_i(afe_o), .cmp_o(cmp_above_i));

    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) xclk_en_i <= ~xclk_en_i;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // whole sequence needs well under 10k cycles
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [7:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one transfer; an idle edge follows so strobes never retoggle at once
    task automatic apb(input logic w, input logic [7:0] ix, d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {2'b00, ix, 2'b00};
        pwdata_i <= {24'h0, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        rv = prdata_o[7:0];
        ev = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h57, 8'h00);
            n++;
        end while (rv[7] !== 1'b1 && n < 40);
        chk("done flag", {7'h0, rv[7]}, 8'h01);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 400) begin
            @(posedge mclk_i);
            n++;
        end
        chk("irq raised", {7'h0, irq_o}, 8'h01);
    endtask

    task automatic chk_reset();
        apb(1'b0, 8'h57, 8'h00);
        chk("status reset", rv, 8'h1f);
        apb(1'b0, 8'h58, 8'h00);
        chk("clock reset", rv, 8'h04);
        apb(1'b0, 8'h5e, 8'h00);
        chk("scan reset", rv, 8'h00);
        chk("irq reset", {7'h0, irq_o}, 8'h00);
    endtask

    initial begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        chk_reset();
        $display("test reset done");
        apb(1'b1, 8'h57, 8'h00);
        wait_done(); // first result after power-up is discarded
        foreach (rows[i]) begin
            apb(1'b1, 8'h58, rows[i][31:24]);
            apb(1'b1, 8'h57, rows[i][23:16]);
            wait_done();
            apb(1'b0, 8'h59, 8'h00);
            chk("result high", rv, rows[i][15:8]);
            apb(1'b0, 8'h5a, 8'h00);
            chk("result low", rv, rows[i][7:0]);
            apb(1'b0, 8'h57, 8'h00);
            chk("status after read", rv, rows[i][23:16]);
        end
        $display("test rows done");
        apb(1'b1, 8'h57, 8'h47);
        wait_irq();
        repeat (5) @(posedge mclk_i);
        chk("irq held", {7'h0, irq_o}, 8'h01);
        apb(1'b0, 8'h57, 8'h00);
        chk("status irq mode", rv, 8'h47);
        apb(1'b0, 8'h5a, 8'h00);
        chk("irq after read", {7'h0, irq_o}, 8'h00);
        apb(1'b1, 8'h57, 8'h40);
        wait_irq();
        apb(1'b1, 8'h57, 8'h5f);
        chk("irq after write", {7'h0, irq_o}, 8'h00);
        repeat (2) @(posedge mclk_i);
        chk("power", {7'h0, afe_o.power}, 8'h00);
        $display("test irq done");
        apb(1'b1, 8'h57, 8'h23);
        wait_done(); // settling result dropped
        apb(1'b0, 8'h5a, 8'h00);
        wait_done();
        apb(1'b1, 8'h57, 8'h03);
        wait_done();
        apb(1'b0, 8'h5a, 8'h00);
        chk("single low", rv, 8'hd5);
        repeat (60) @(posedge mclk_i);
        apb(1'b0, 8'h57, 8'h00);
        chk("no restart", rv, 8'h03);
        $display("test continuous done");
        apb(1'b1, 8'h57, 8'h07);
        repeat (8) @(posedge mclk_i);
        stop_i <= 1'b1;
        repeat (60) @(posedge mclk_i);
        apb(1'b0, 8'h57, 8'h00);
        chk("stopped", rv, 8'h07);
        stop_i <= 1'b0;
        wait_done(); // settling conversion
        apb(1'b0, 8'h5a, 8'h00);
        chk("after stop", rv, 8'hd5);
        $display("test stop done");
        apb(1'b1, 8'h58, 8'h10);
        apb(1'b1, 8'h5e, 8'h07);
        apb(1'b1, 8'h57, 8'h40); // continuous stays clear
        wait_irq();
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'h5a + 8'(k), 8'h00);
            chk("scan result", rv, 8'h15 + 8'(k * 32));
        end
        apb(1'b1, 8'h5e, 8'h00);
        chk("mapped err", {7'h0, ev}, 8'h00);
        apb(1'b0, 8'h60, 8'h00);
        chk("unmapped err", {7'h0, ev}, 8'h01);
        $display("test scan done");
        apb(1'b1, 8'h57, 8'h60);
        apb(1'b1, 8'h58, 8'h1c);
        sys_rst_i <= 1'b1;
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        chk_reset();
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
